// file: hw/tap_decoder.sv
// One-hot tap switch decoder driven by the wiper position
`timescale 1ns/100ps
module tap_decoder #(
    parameter int VALUE_W = wiper_pot_pkg::VALUE_W,
    parameter int TAPS    = wiper_pot_pkg::TAPS
) (
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_int_n,
    // Wiper position in, switch enables out
    input  wire logic [VALUE_W-1:0] position,
    output logic      [TAPS-1:0]    tap_select
);
    import wiper_pot_pkg::*;

    logic [TAPS-1:0] decoded;

    // Equality against a distinct index per tap, so only one bit can ever be high
    for (genvar i = 0; i < TAPS; i++) begin : g_tap
        assign decoded[i] = (position == VALUE_W'(i));
    end

    // Registered so the switch enables never glitch through two taps
    always_ff @(posedge mclk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            tap_select <= TAPS'(1);
        end else begin
            tap_select <= decoded;
        end
    end

endmodule

// file: hw/wiper_pot_pkg.sv
// Shared constants and types for the serial wiper potentiometer slave
package wiper_pot_pkg;

    // ------------------------------------------------------------------
    // Value and array sizes
    // ------------------------------------------------------------------
    localparam int VALUE_W    = 10;
    localparam int TAPS       = 1024;
    localparam int NUM_STORED = 4;
    localparam int PTR_W      = 2;
    localparam int HI_BITS    = 2;
    localparam int BIT_CNT_W  = 4;

    localparam logic [VALUE_W-1:0] STORED_RESET = 10'h000;
    localparam logic [VALUE_W-1:0] WIPER_RESET  = 10'h000;

    // Arbitrary device type code, not taken from any real part
    localparam logic [3:0] DEVICE_TYPE_DFLT = 4'hA;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ID_TYPE_MSB = 7;
    localparam int ID_TYPE_LSB = 4;
    localparam int ID_ADDR_MSB = 3;
    localparam int ID_ADDR_LSB = 1;
    localparam int ID_DIR_BIT  = 0;
    localparam int OP_MSB      = 7;
    localparam int OP_LSB      = 5;
    localparam int ZERO_HI_BIT = 4;
    localparam int PTR_MSB     = 3;
    localparam int PTR_LSB     = 2;
    localparam int ZERO_LO_MSB = 1;

    localparam logic       DIR_READ  = 1'b1;
    localparam logic [2:0] OP_RD_WIPER  = 3'h4;
    localparam logic [2:0] OP_WR_WIPER  = 3'h5;
    localparam logic [2:0] OP_RD_STORED = 3'h5;
    localparam logic [2:0] OP_WR_STORED = 3'h6;
    localparam logic [2:0] OP_TO_WIPER  = 3'h6;
    localparam logic [2:0] OP_TO_STORED = 3'h7;

    localparam logic [BIT_CNT_W-1:0] LAST_BIT      = 4'h7;
    localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;

    localparam logic [1:0] BYTE_ID      = 2'h0;
    localparam logic [1:0] BYTE_INSTR   = 2'h1;
    localparam logic [1:0] BYTE_DATA_HI = 2'h2;
    localparam logic [1:0] BYTE_DATA_LO = 2'h3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ          = 20;
    localparam int NV_WRITE_TIME_US = 5000;
    localparam int NV_WRITE_CYCLES_DFLT = NV_WRITE_TIME_US * CLK_MHZ;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_RD_WIPER,
        CMD_WR_WIPER,
        CMD_RD_STORED,
        CMD_WR_STORED,
        CMD_TO_WIPER,
        CMD_TO_STORED
    } cmd_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_MACK,
        ST_IGNORE
    } state_e;

endpackage

// file: hw/wiper_pot_serial_command_slave.sv
// Two-wire command slave for a 1024-tap potentiometer with four stored settings
//
// How it works
// - Ten wiper bits decode to enable one of 1024 tap switches.
// - Never more than one tap switch is on at once.
// - Data line changes only while the clock is low, except start/stop.
// - Start is data falling with clock high; nothing answered before one.
// - Stop is data rising with clock high; it ends the command.
// - After eight bits the sender releases data; receiver pulls low on ninth clock.
// - Acknowledge address, instruction and each received data byte.
// - Stop after a nonvolatile write starts the internal write; inputs disabled meanwhile.
// - No address acknowledge while the internal write runs; normal afterwards.
// - Upper four bits of the first byte must equal the device type.
// - Three address bits must equal the strapped address inputs.
// - First byte LSB: one means read, zero means write.
// - Top three bits of the instruction are the opcode.
// - Two pointer bits select stored setting zero to three.
// - Read 100 returns the wiper; write 101 loads the wiper.
// - Read 101 returns a stored setting; write 110 writes it.
// - Read 110 copies stored to wiper; write 111 copies wiper to stored.
// - Wiper changes only by write, transfer, or power-up load of setting zero.
// - Wiper is volatile; after power-up it holds setting zero.
// - Master makes the clock; device is only a slave.
// - Sample on rising clock, shift out after falling clock.
// - Write protect low refuses every nonvolatile write.
// - Four ten-bit stored settings; each write finishes within 5ms.
`timescale 1ns/100ps
module wiper_pot_serial_command_slave #(
    parameter int         NV_WRITE_CYCLES = wiper_pot_pkg::NV_WRITE_CYCLES_DFLT,
    parameter logic [3:0] DEVICE_TYPE     = wiper_pot_pkg::DEVICE_TYPE_DFLT
) (
    // Clock and reset
    input  wire logic                             mclk,
    input  wire logic                             rst_n,
    // Two-wire bus, open drain data
    input  wire logic                             scl,
    input  wire logic                             sda_i,
    output logic                                  sda_o,
    output logic                                  sda_oe,
    // Straps
    input  wire logic [2:0]                       strapped_address_inputs,
    input  wire logic                             write_protect_n,
    // Potentiometer and status
    output logic      [wiper_pot_pkg::TAPS-1:0]   tap_select,
    output logic                                  nv_write_busy
);
    import wiper_pot_pkg::*;

    localparam int CNT_W = $clog2(NV_WRITE_CYCLES + 1);
    localparam logic [CNT_W-1:0] NV_LOAD = CNT_W'(NV_WRITE_CYCLES);

    // ------------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------------
    function automatic cmd_e decode_cmd(input logic dir, input logic [7:0] b);
        logic       ptr_zero;
        logic [3:0] key;
        cmd_e       c;
        ptr_zero = (b[PTR_MSB:PTR_LSB] == 2'h0);
        key      = {dir, b[OP_MSB:OP_LSB]};
        c        = CMD_NONE;
        if (!b[ZERO_HI_BIT] && b[ZERO_LO_MSB:0] == 2'h0) begin
            case (key)
                {DIR_READ, OP_RD_WIPER}:   c = ptr_zero ? CMD_RD_WIPER : CMD_NONE;
                {~DIR_READ, OP_WR_WIPER}:  c = ptr_zero ? CMD_WR_WIPER : CMD_NONE;
                {DIR_READ, OP_RD_STORED}:  c = CMD_RD_STORED;
                {~DIR_READ, OP_WR_STORED}: c = CMD_WR_STORED;
                {DIR_READ, OP_TO_WIPER}:   c = CMD_TO_WIPER;
                {~DIR_READ, OP_TO_STORED}: c = CMD_TO_STORED;
                default:                   c = CMD_NONE;
            endcase
        end
        return c;
    endfunction

    // ------------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_int_n;
    logic [5:0] pin_meta_q;
    logic [5:0] pin_sync_q;
    logic [1:0] line_prev_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_int_n = rst_sync_q[1];

    // Lines idle high, so they reset high to avoid a false start at release
    always_ff @(posedge mclk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            pin_meta_q  <= 6'h3F;
            pin_sync_q  <= 6'h3F;
            line_prev_q <= 2'h3;
        end else begin
            pin_meta_q  <= {scl, sda_i, write_protect_n, strapped_address_inputs};
            pin_sync_q  <= pin_meta_q;
            line_prev_q <= pin_sync_q[5:4];
        end
    end

    logic       scl_s;
    logic       sda_s;
    logic       wp_n_s;
    logic [2:0] strap_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;

    assign scl_s      = pin_sync_q[5];
    assign sda_s      = pin_sync_q[4];
    assign wp_n_s     = pin_sync_q[3];
    assign strap_s    = pin_sync_q[2:0];
    assign scl_rise   = scl_s && !line_prev_q[1];
    assign scl_fall   = !scl_s && line_prev_q[1];
    assign start_seen = scl_s && line_prev_q[1] && line_prev_q[0] && !sda_s;
    assign stop_seen  = scl_s && line_prev_q[1] && !line_prev_q[0] && sda_s;

    // ------------------------------------------------------------------
    // Protocol and register state
    // ------------------------------------------------------------------
    state_e                 state_q,    state_d;
    logic [BIT_CNT_W-1:0]   bit_cnt_q,  bit_cnt_d;
    logic [1:0]             byte_idx_q, byte_idx_d;
    logic [7:0]             shift_q,    shift_d;
    logic [7:0]             tx_q,       tx_d;
    logic                   ack_q,      ack_d;
    logic                   dir_q,      dir_d;
    logic                   mack_q,     mack_d;
    cmd_e                   cmd_q,      cmd_d;
    logic [PTR_W-1:0]       ptr_q,      ptr_d;
    logic [HI_BITS-1:0]     hi_q,       hi_d;
    logic [VALUE_W-1:0]     wiper_q,    wiper_d;
    logic [VALUE_W-1:0]     stored_q [NUM_STORED];
    logic [VALUE_W-1:0]     stored_d [NUM_STORED];
    logic                   nv_pend_q,  nv_pend_d;
    logic [PTR_W-1:0]       nv_ptr_q,   nv_ptr_d;
    logic [VALUE_W-1:0]     nv_val_q,   nv_val_d;
    logic [CNT_W-1:0]       busy_cnt_q, busy_cnt_d;
    logic                   loaded_q,   loaded_d;
    logic                   sda_oe_q,   sda_oe_d;

    logic [7:0]             byte_in;
    logic [VALUE_W-1:0]     read_val;
    cmd_e                   cmd_new;
    logic                   busy;

    assign byte_in  = {shift_q[6:0], sda_s};
    assign busy     = (busy_cnt_q != '0);
    assign read_val = (cmd_q == CMD_RD_WIPER) ? wiper_q : stored_q[ptr_q];
    assign cmd_new  = decode_cmd(dir_q, byte_in);

    always_comb begin
        state_d    = state_q;
        bit_cnt_d  = bit_cnt_q;
        byte_idx_d = byte_idx_q;
        shift_d    = shift_q;
        tx_d       = tx_q;
        ack_d      = ack_q;
        dir_d      = dir_q;
        mack_d     = mack_q;
        cmd_d      = cmd_q;
        ptr_d      = ptr_q;
        hi_d       = hi_q;
        wiper_d    = wiper_q;
        stored_d   = stored_q;
        nv_pend_d  = nv_pend_q;
        nv_ptr_d   = nv_ptr_q;
        nv_val_d   = nv_val_q;
        busy_cnt_d = busy ? busy_cnt_q - CNT_W'(1) : busy_cnt_q;
        loaded_d   = 1'b1;

        // Power-up recall of setting zero into the volatile wiper
        if (!loaded_q) begin
            wiper_d = stored_q[0];
        end

        if (start_seen) begin
            // A repeated start also drops any unfinished write command
            state_d    = ST_RX;
            bit_cnt_d  = '0;
            byte_idx_d = BYTE_ID;
            ack_d      = 1'b0;
            nv_pend_d  = 1'b0;
        end else if (stop_seen) begin
            state_d   = ST_IDLE;
            nv_pend_d = 1'b0;
            if (nv_pend_q) begin
                stored_d[nv_ptr_q] = nv_val_q;
                busy_cnt_d         = NV_LOAD;
            end
        end else if (scl_rise) begin
            unique case (state_q)
                ST_RX: begin
                    shift_d   = byte_in;
                    bit_cnt_d = bit_cnt_q + BIT_CNT_W'(1);
                    if (bit_cnt_q == LAST_BIT) begin
                        ack_d = 1'b0;
                        unique case (byte_idx_q)
                            BYTE_ID: begin
                                dir_d = byte_in[ID_DIR_BIT];
                                ack_d = byte_in[ID_TYPE_MSB:ID_TYPE_LSB] == DEVICE_TYPE
                                     && byte_in[ID_ADDR_MSB:ID_ADDR_LSB] == strap_s
                                     && !busy;
                            end
                            BYTE_INSTR: begin
                                cmd_d = cmd_new;
                                ptr_d = byte_in[PTR_MSB:PTR_LSB];
                                ack_d = (cmd_new != CMD_NONE);
                                if (cmd_new == CMD_TO_WIPER) begin
                                    wiper_d = stored_q[byte_in[PTR_MSB:PTR_LSB]];
                                end
                                if (cmd_new == CMD_TO_STORED) begin
                                    nv_pend_d = wp_n_s;
                                    nv_ptr_d  = byte_in[PTR_MSB:PTR_LSB];
                                    nv_val_d  = wiper_q;
                                end
                            end
                            BYTE_DATA_HI: begin
                                hi_d  = byte_in[HI_BITS-1:0];
                                ack_d = 1'b1;
                            end
                            BYTE_DATA_LO: begin
                                ack_d = 1'b1;
                                if (cmd_q == CMD_WR_WIPER) begin
                                    wiper_d = {hi_q, byte_in};
                                end
                                if (cmd_q == CMD_WR_STORED) begin
                                    nv_pend_d = wp_n_s;
                                    nv_ptr_d  = ptr_q;
                                    nv_val_d  = {hi_q, byte_in};
                                end
                            end
                        endcase
                    end
                end
                ST_MACK: mack_d = !sda_s;
                default: ;
            endcase
        end else if (scl_fall) begin
            unique case (state_q)
                ST_RX: begin
                    if (bit_cnt_q == BITS_PER_BYTE) begin
                        state_d = ack_q ? ST_ACK : ST_IGNORE;
                    end
                end
                ST_ACK: begin
                    bit_cnt_d  = '0;
                    byte_idx_d = byte_idx_q + 2'h1;
                    if (byte_idx_q == BYTE_INSTR
                        && (cmd_q == CMD_RD_WIPER || cmd_q == CMD_RD_STORED)) begin
                        tx_d    = {{(8 - HI_BITS){1'b0}}, read_val[VALUE_W-1:8]};
                        state_d = ST_TX;
                    end else if (byte_idx_q == BYTE_DATA_LO
                                 || (byte_idx_q == BYTE_INSTR
                                     && (cmd_q == CMD_TO_WIPER || cmd_q == CMD_TO_STORED))) begin
                        state_d = ST_IGNORE;
                    end else begin
                        state_d = ST_RX;
                    end
                end
                ST_TX: begin
                    bit_cnt_d = bit_cnt_q + BIT_CNT_W'(1);
                    tx_d      = {tx_q[6:0], 1'b0};
                    if (bit_cnt_q == LAST_BIT) begin
                        mack_d  = 1'b0;
                        state_d = ST_MACK;
                    end
                end
                ST_MACK: begin
                    if (mack_q && byte_idx_q == BYTE_DATA_HI) begin
                        tx_d       = read_val[7:0];
                        byte_idx_d = BYTE_DATA_LO;
                        bit_cnt_d  = '0;
                        state_d    = ST_TX;
                    end else begin
                        state_d = ST_IGNORE;
                    end
                end
                default: ;
            endcase
        end

        // Only pull low, and only right after a falling clock edge
        sda_oe_d = (state_d == ST_ACK && ack_d) || (state_d == ST_TX && !tx_d[7]);
    end

    always_ff @(posedge mclk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            state_q    <= ST_IDLE;
            bit_cnt_q  <= '0;
            byte_idx_q <= BYTE_ID;
            shift_q    <= 8'h00;
            tx_q       <= 8'h00;
            ack_q      <= 1'b0;
            dir_q      <= 1'b0;
            mack_q     <= 1'b0;
            cmd_q      <= CMD_NONE;
            ptr_q      <= '0;
            hi_q       <= '0;
            wiper_q    <= WIPER_RESET;
            stored_q   <= '{default: STORED_RESET};
            nv_pend_q  <= 1'b0;
            nv_ptr_q   <= '0;
            nv_val_q   <= STORED_RESET;
            busy_cnt_q <= '0;
            loaded_q   <= 1'b0;
            sda_oe_q   <= 1'b0;
        end else begin
            state_q    <= state_d;
            bit_cnt_q  <= bit_cnt_d;
            byte_idx_q <= byte_idx_d;
            shift_q    <= shift_d;
            tx_q       <= tx_d;
            ack_q      <= ack_d;
            dir_q      <= dir_d;
            mack_q     <= mack_d;
            cmd_q      <= cmd_d;
            ptr_q      <= ptr_d;
            hi_q       <= hi_d;
            wiper_q    <= wiper_d;
            stored_q   <= stored_d;
            nv_pend_q  <= nv_pend_d;
            nv_ptr_q   <= nv_ptr_d;
            nv_val_q   <= nv_val_d;
            busy_cnt_q <= busy_cnt_d;
            loaded_q   <= loaded_d;
            sda_oe_q   <= sda_oe_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign sda_o         = 1'b0;
    assign sda_oe        = sda_oe_q;
    assign nv_write_busy = busy;

    tap_decoder #(
        .VALUE_W (VALUE_W),
        .TAPS    (TAPS)
    ) u_tap_decoder (
        .mclk       (mclk),
        .rst_int_n  (rst_int_n),
        .position   (wiper_q),
        .tap_select (tap_select)
    );

endmodule

// file: verification/bus_master_model.sv
// Behavioural two-wire bus master facing the slave
`timescale 1ns/100ps
module bus_master_model (
    // Clock and sensed data line
    input  wire logic mclk,
    input  wire logic sda_line,
    // Bus lines, data released reads high by pull-up
    output logic      scl,
    output logic      sda_m
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Data moves deep in the low phase so the slave's late answer never collides
    task automatic bit_x(input logic b, output logic r);
        sda_m = b;
        w(1);
        scl = 1'b1;
        w(2);
        r = sda_line;
        w(1);
        scl = 1'b0;
        w(4);
    endtask
    task automatic start();
        sda_m = 1'b1;
        w(1);
        scl = 1'b1;
        w(2);
        sda_m = 1'b0;
        w(2);
        scl = 1'b0;
        w(4);
    endtask
    task automatic stop();
        sda_m = 1'b0;
        w(1);
        scl = 1'b1;
        w(2);
        sda_m = 1'b1;
        w(4);
    endtask
    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask
    task automatic rx(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(!mack, r);
    endtask
endmodule

// file: verification/wiper_pot_serial_command_slave_tb_top.sv
// Self-checking bench for the wiper potentiometer command slave
`timescale 1ns/100ps
module wiper_pot_serial_command_slave_tb_top;
    import wiper_pot_pkg::*;
    localparam int         NVC  = 200;
    localparam logic [2:0] ADDR = 3'h5;
    localparam logic [7:0] ID_W = {DEVICE_TYPE_DFLT, ADDR, 1'b0};
    localparam logic [7:0] ID_R = {DEVICE_TYPE_DFLT, ADDR, 1'b1};
    logic            mclk, rst_n, scl, sda_m, sda_o, sda_oe, wp_n, busy;
    logic [TAPS-1:0] tap;
    logic [9:0]      st [4];
    logic [9:0]      rv;
    logic [3:0]      ak;
    int              n_errors, total_checks;
    wire             sda_line;
    assign sda_line = sda_oe ? (sda_m & sda_o) : sda_m;

    wiper_pot_serial_command_slave #(.NV_WRITE_CYCLES(NVC)) i_dut (
        .mclk(mclk), .rst_n(rst_n), .scl(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .strapped_address_inputs(ADDR), .write_protect_n(wp_n), .tap_select(tap), .nv_write_busy(busy));
    bus_master_model m (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Whole command: acks land in ak[3:0], read value in rv
    task automatic op(input logic [7:0] idb, input logic [7:0] ins, input logic dat, input logic [9:0] v);
        logic [7:0] h;
        logic [7:0] l;
        ak = 4'h0;
        rv = 10'h000;
        m.start();
        m.tx(idb, ak[3]);
        m.tx(ins, ak[2]);
        if (dat && idb[0]) begin
            m.rx(1'b1, h);
            m.rx(1'b0, l);
            rv = {h[1:0], l};
        end else if (dat) begin
            m.tx({6'h00, v[9:8]}, ak[1]);
            m.tx(v[7:0], ak[0]);
        end
        m.stop();
    endtask
    task automatic poll();
        logic a;
        a = 1'b0;
        for (int i = 0; i < 40 && !a; i++) begin
            m.start();
            m.tx(ID_W, a);
            m.stop();
            if (i == 0) chk(16'(a), 16'h0);
        end
        chk(16'(a), 16'h1);
        if (!a) tally_and_finish();
    endtask
    task automatic s_wiper();
        logic [9:0] vals [4] = '{10'h3FF, 10'h155, 10'h200, 10'h001};
        chk(16'(tap[0]), 16'h1);
        foreach (vals[i]) begin
            op(ID_W, 8'hA0, 1'b1, vals[i]);
            chk(16'(ak), 16'hF);
            chk(16'(tap[vals[i]]), 16'h1);
            op(ID_R, 8'h80, 1'b1, 10'h000);
            chk(16'(ak[3:2]), 16'h3);
            chk(16'(rv), 16'(vals[i]));
        end
    endtask
    task automatic s_refuse();
        m.tx(ID_W, ak[0]);
        m.stop();
        chk(16'(ak[0]), 16'h0);
        op({DEVICE_TYPE_DFLT ^ 4'h3, ADDR, 1'b0}, 8'hA0, 1'b1, 10'h0F0);
        chk(16'(ak), 16'h0);
        op({DEVICE_TYPE_DFLT, ~ADDR, 1'b0}, 8'hA0, 1'b1, 10'h0F0);
        chk(16'(ak), 16'h0);
        op(ID_R, 8'hE0, 1'b0, 10'h000);
        chk(16'(ak), 16'h8);
        op(ID_W, 8'h80, 1'b1, 10'h0F0);
        chk(16'(ak), 16'h8);
        op(ID_W, 8'hA4, 1'b1, 10'h0F0);
        chk(16'(ak), 16'h8);
        chk(16'(tap[1]), 16'h1);
    endtask
    task automatic s_stored();
        for (int p = 0; p < 4; p++) begin
            st[p] = 10'h2C3 ^ 10'(p * 37);
            op(ID_W, {3'h6, 1'b0, 2'(p), 2'b00}, 1'b1, st[p]);
            m.w(2);
            chk(16'(ak), 16'hF);
            chk(16'(busy), 16'h1);
            poll();
        end
        for (int p = 0; p < 4; p++) begin
            op(ID_R, {3'h5, 1'b0, 2'(p), 2'b00}, 1'b1, 10'h000);
            chk(16'(rv), 16'(st[p]));
        end
        op(ID_R, {3'h6, 1'b0, 2'h2, 2'b00}, 1'b0, 10'h000);
        chk(16'(ak), 16'hC);
        chk(16'(tap[st[2]]), 16'h1);
        op(ID_W, 8'hA0, 1'b1, 10'h0AB);
        op(ID_W, {3'h7, 1'b0, 2'h3, 2'b00}, 1'b0, 10'h000);
        poll();
        op(ID_R, {3'h5, 1'b0, 2'h3, 2'b00}, 1'b1, 10'h000);
        chk(16'(rv), 16'h0AB);
    endtask
    task automatic s_protect();
        wp_n = 1'b0;
        m.w(4);
        op(ID_W, {3'h6, 1'b0, 2'h1, 2'b00}, 1'b1, 10'h3AA);
        m.w(2);
        chk(16'(ak), 16'hF);
        chk(16'(busy), 16'h0);
        wp_n = 1'b1;
        op(ID_R, {3'h5, 1'b0, 2'h1, 2'b00}, 1'b1, 10'h000);
        chk(16'(rv), 16'(st[1]));
    endtask

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Watchdog: a stalled run counts as a mismatch
    initial begin
        repeat (60000) @(posedge mclk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        rst_n = 1'b0;
        wp_n = 1'b1;
        n_errors = 0;
        total_checks = 0;
        repeat (16) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        m.w(8);
        s_wiper();
        s_refuse();
        s_stored();
        s_protect();
        tally_and_finish();
    end
endmodule

// file: verification/wiper_pot_sva.sv
// Pin-level checks for the wiper potentiometer command slave
`timescale 1ns/100ps
module wiper_pot_sva #(
    parameter int NV_WRITE_CYCLES = 200
) (
    // Clock and reset
    input wire logic                           mclk,
    input wire logic                           rst_n,
    // Bus lines
    input wire logic                           scl,
    input wire logic                           sda_i,
    input wire logic                           sda_o,
    input wire logic                           sda_oe,
    // Straps
    input wire logic [2:0]                     strapped_address_inputs,
    input wire logic                           write_protect_n,
    // Potentiometer and status
    input wire logic [wiper_pot_pkg::TAPS-1:0] tap_select,
    input wire logic                           nv_write_busy
);
    logic [31:0] busy_cnt_d;
    logic [31:0] busy_cnt_q;

    // ------------------------------------------------------------------
    // Busy length counter
    // ------------------------------------------------------------------
    always_comb begin
        busy_cnt_d = nv_write_busy ? busy_cnt_q + 32'h1 : 32'h0;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence stop_seen;
        scl && $rose(sda_i);
    endsequence
    sequence ack_hold;
        sda_oe [*8];
    endsequence

    tap_onehot_a: assert property ($onehot(tap_select))
        else $error("tap select not one-hot");
    sda_pull_low_a: assert property (sda_oe |-> !sda_o)
        else $error("data line driven high");
    ack_hold_a: assert property ($rose(sda_oe) |-> ack_hold)
        else $error("data low shorter than one bus clock");
    sda_edge_a: assert property ($changed(sda_oe) |-> !scl && ($past(scl, 3) || $past(scl, 4) || $past(scl, 5)))
        else $error("data line moved outside clock low after a fall");
    stop_quiet_a: assert property (stop_seen |-> !sda_oe [*4])
        else $error("data driven after stop");
    reset_quiet_a: assert property ($rose(rst_n) |-> !sda_oe [*8])
        else $error("data driven before any start");
    busy_start_a: assert property ($rose(nv_write_busy) |-> scl && sda_i)
        else $error("write cycle began without a stop");
    busy_len_a: assert property ($fell(nv_write_busy) |-> busy_cnt_q >= NV_WRITE_CYCLES && busy_cnt_q <= NV_WRITE_CYCLES + 1)
        else $error("write cycle length wrong");
    busy_mute_a: assert property (nv_write_busy |-> !sda_oe)
        else $error("acknowledge while writing");
    wp_block_a: assert property ($rose(nv_write_busy) |-> $past(write_protect_n, 4))
        else $error("write cycle under write protect");
    tap_move_a: assert property ($changed(tap_select) |-> $past(scl, 3) || $past(scl, 4) || $past(scl, 5))
        else $error("tap moved without a clocked bit");
endmodule

bind wiper_pot_serial_command_slave wiper_pot_sva #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) i_sva (
    .mclk(mclk), .rst_n(rst_n), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .strapped_address_inputs(strapped_address_inputs), .write_protect_n(write_protect_n),
    .tap_select(tap_select), .nv_write_busy(nv_write_busy));
